/* hw/gcf_flag_logic.sv */
// Gain-control flag logic top: registers, instability indicator, peak
// threshold compare, pin source select and interrupt.
// Assumes peak and sample strobes come from logic on clk.
//
// Operation
// [RULE1] Writing one to clear bit clears indicator
// [RULE2] Overload detection sets sticky indicator, bit zero
// [RULE3] Only clear bit or resets clear indicator
// [RULE4] First upper threshold: twelve bits, two registers
// [RULE5] Second upper threshold: twelve bits, two registers
// [RULE6] Lower threshold twelve bits, resets to zero
// [RULE7] Dwell mantissa eight bits, exponent four bits
// [RULE8] Pin A select; code zero gives pulse
// [RULE9] Pin B select, same encoding
// [RULE10] Code 100: peak above first threshold
// [RULE11] Code 101: peak above second threshold
// [RULE12] Code 110: below lower threshold for dwell
// [RULE13] Combine bit ORs reset pulse into pins
// [RULE14] Pin B low unless its enable set
// [RULE15] Pin A low unless its enable set
// [RULE16] Overload: full-scale count over limit in eight
// [RULE17] Reset pulse lasts length plus one, times eight
// [RULE18] Unused codes drive low; dwell is shifted mantissa
`timescale 1ns/1ps
module gcf_flag_logic (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               soft_rst,
  input  wire logic [8:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  input  wire logic               sample_valid,
  input  wire logic signed [4:0]  sample,
  input  wire logic               peak_valid,
  input  wire logic [11:0]        decimated_output,
  output logic                    overload_reset,
  output logic                    indicator_pin_a,
  output logic                    indicator_pin_b,
  output logic                    irq
);

  typedef struct packed {
    logic       unstable;
    logic       clr_pend;
    logic [7:0] up0_low;
    logic [3:0] up0_high;
    logic [7:0] up1_low;
    logic [3:0] up1_high;
    logic [7:0] lower_low;
    logic [3:0] lower_high;
    logic [7:0] hold_frac;
    logic [3:0] hold_scale;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic       en_a;
    logic       en_b;
    logic       en_or;
    logic [2:0] ovl_limit;
    logic [4:0] ovl_len;
    logic       above0;
    logic       above1;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] rdata;
    logic       pin_a;
    logic       pin_b;
    logic       irq;
    logic       ovl_out;
  } gcf_main_t;

  gcf_main_t   st;
  gcf_main_t   next_st;
  logic        ovl_trig;
  logic        ovl_pulse;
  logic        dwell_flag;
  logic [11:0] thr0;
  logic [11:0] thr1;
  logic [11:0] thr_low;

  // ****************************************************************
  // Threshold assembly
  // ****************************************************************
  assign thr0 = {st.up0_high, st.up0_low}; // [RULE4]
  assign thr1 = {st.up1_high, st.up1_low}; // [RULE5]
  assign thr_low = {st.lower_high, st.lower_low}; // [RULE6]

  // ****************************************************************
  // Submodules
  // ****************************************************************
  gcf_overload_det u_det (
    .clk          (clk),
    .rst          (rst),
    .soft_rst     (soft_rst),
    .sample_valid (sample_valid),
    .sample       (sample),
    .count_limit  (st.ovl_limit),
    .pulse_length (st.ovl_len),
    .trigger      (ovl_trig),
    .pulse        (ovl_pulse)
  );

  gcf_dwell_timer u_dwell (
    .clk        (clk),
    .rst        (rst),
    .soft_rst   (soft_rst),
    .peak_valid (peak_valid),
    .peak       (decimated_output),
    .lower      (thr_low),
    .mantissa   (st.hold_frac), // [RULE7]
    .exponent   (st.hold_scale),
    .flag       (dwell_flag)
  );

  // ****************************************************************
  // Pin source select
  // ****************************************************************
  function automatic logic pick(input logic [2:0] sel, input logic orin,
                                input logic pulse, input logic a0,
                                input logic a1, input logic dw);
    logic f;
    unique case (sel)
      gcf_pkg::SEL_OVL_PULSE: f = pulse; // [RULE8]
      gcf_pkg::SEL_ABOVE0:    f = a0; // [RULE10]
      gcf_pkg::SEL_ABOVE1:    f = a1; // [RULE11]
      gcf_pkg::SEL_DWELL:     f = dw; // [RULE12]
      default:                f = 1'b0; // [RULE18]
    endcase
    return f | (orin & pulse); // [RULE13]
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [3:0] events;
    logic       wr_clr;
    next_st = st;
    events = '0;
    wr_clr = 1'b0;
    next_st.rdata = 8'h00;
    next_st.clr_pend = 1'b0; // [RULE1]
    if (peak_valid) begin
      next_st.above0 = decimated_output > thr0; // [RULE10]
      next_st.above1 = decimated_output > thr1; // [RULE11]
    end
    events[gcf_pkg::EVT_OVERLOAD] = ovl_trig;
    events[gcf_pkg::EVT_ABOVE0] = next_st.above0 & ~st.above0;
    events[gcf_pkg::EVT_ABOVE1] = next_st.above1 & ~st.above1;
    events[gcf_pkg::EVT_DWELL] = dwell_flag & ~st.pin_a & ~st.pin_b
                                 & (st.status[gcf_pkg::EVT_DWELL] == 1'b0);
    if (reg_wr) begin
      unique case (reg_addr)
        gcf_pkg::OFS_OVL_LIMIT:  next_st.ovl_limit = reg_wdata[2:0];
        gcf_pkg::OFS_OVL_LEN:    next_st.ovl_len = reg_wdata[4:0];
        gcf_pkg::OFS_INSTAB_CTL: begin
          next_st.clr_pend = reg_wdata[gcf_pkg::BIT_INSTAB_CLR]; // [RULE1]
        end
        gcf_pkg::OFS_UP0_LOW:    next_st.up0_low = reg_wdata; // [RULE4]
        gcf_pkg::OFS_UP0_HIGH:   next_st.up0_high = reg_wdata[3:0];
        gcf_pkg::OFS_UP1_LOW:    next_st.up1_low = reg_wdata; // [RULE5]
        gcf_pkg::OFS_UP1_HIGH:   next_st.up1_high = reg_wdata[3:0];
        gcf_pkg::OFS_LOWER_LOW:  next_st.lower_low = reg_wdata; // [RULE6]
        gcf_pkg::OFS_LOWER_HIGH: next_st.lower_high = reg_wdata[3:0];
        gcf_pkg::OFS_HOLD_FRAC:  next_st.hold_frac = reg_wdata; // [RULE7]
        gcf_pkg::OFS_HOLD_SCALE: next_st.hold_scale = reg_wdata[3:0];
        gcf_pkg::OFS_PIN_A_SEL:  next_st.sel_a = reg_wdata[2:0]; // [RULE8]
        gcf_pkg::OFS_PIN_B_SEL:  next_st.sel_b = reg_wdata[2:0]; // [RULE9]
        gcf_pkg::OFS_PIN_ENABLE: begin
          next_st.en_a = reg_wdata[gcf_pkg::BIT_EN_A];
          next_st.en_b = reg_wdata[gcf_pkg::BIT_EN_B];
          next_st.en_or = reg_wdata[gcf_pkg::BIT_EN_OR];
        end
        gcf_pkg::OFS_IRQ_STATUS: wr_clr = 1'b1;
        gcf_pkg::OFS_IRQ_MASK:   next_st.mask = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (wr_clr) begin
      next_st.status = st.status & ~reg_wdata[3:0];
    end
    next_st.status = next_st.status | events;
    if (st.clr_pend) begin
      next_st.unstable = 1'b0; // [RULE3]
    end
    if (ovl_trig) begin
      next_st.unstable = 1'b1; // [RULE2]
    end
    if (reg_rd) begin
      unique case (reg_addr)
        gcf_pkg::OFS_OVL_LIMIT:  next_st.rdata = {5'h00, st.ovl_limit};
        gcf_pkg::OFS_OVL_LEN:    next_st.rdata = {3'h0, st.ovl_len};
        gcf_pkg::OFS_INSTAB_CTL: begin
          next_st.rdata = {6'h00, st.clr_pend, st.unstable}; // [RULE2]
        end
        gcf_pkg::OFS_UP0_LOW:    next_st.rdata = st.up0_low;
        gcf_pkg::OFS_UP0_HIGH:   next_st.rdata = {4'h0, st.up0_high};
        gcf_pkg::OFS_UP1_LOW:    next_st.rdata = st.up1_low;
        gcf_pkg::OFS_UP1_HIGH:   next_st.rdata = {4'h0, st.up1_high};
        gcf_pkg::OFS_LOWER_LOW:  next_st.rdata = st.lower_low;
        gcf_pkg::OFS_LOWER_HIGH: next_st.rdata = {4'h0, st.lower_high};
        gcf_pkg::OFS_HOLD_FRAC:  next_st.rdata = st.hold_frac;
        gcf_pkg::OFS_HOLD_SCALE: next_st.rdata = {4'h0, st.hold_scale};
        gcf_pkg::OFS_PIN_A_SEL:  next_st.rdata = {5'h00, st.sel_a};
        gcf_pkg::OFS_PIN_B_SEL:  next_st.rdata = {5'h00, st.sel_b};
        gcf_pkg::OFS_PIN_ENABLE: begin
          next_st.rdata = {3'h0, st.en_or, 2'h0, st.en_b, st.en_a};
        end
        gcf_pkg::OFS_IRQ_STATUS: next_st.rdata = {4'h0, st.status};
        gcf_pkg::OFS_IRQ_MASK:   next_st.rdata = {4'h0, st.mask};
        default:                 next_st.rdata = 8'h00;
      endcase
    end
    next_st.pin_a = st.en_a & pick(st.sel_a, st.en_or, ovl_pulse, // [RULE15]
                                   st.above0, st.above1, dwell_flag);
    next_st.pin_b = st.en_b & pick(st.sel_b, st.en_or, ovl_pulse, // [RULE14]
                                   st.above0, st.above1, dwell_flag);
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.ovl_out = ovl_pulse;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      st <= '0; // [RULE3]
      st.ovl_limit <= gcf_pkg::RST_OVL_LIMIT;
      st.ovl_len <= gcf_pkg::RST_OVL_LEN;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign indicator_pin_a = st.pin_a;
  assign indicator_pin_b = st.pin_b;
  assign irq = st.irq;
  assign overload_reset = st.ovl_out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || soft_rst);

  a_clear_self_zero : assert property ( // [RULE1]
    reg_wr && reg_addr == gcf_pkg::OFS_INSTAB_CTL && reg_wdata[1]
    |=> st.clr_pend ##1 !st.clr_pend) else $error("clear bit stuck");
  a_clear_takes_flag : assert property ( // [RULE1]
    st.clr_pend && !ovl_trig |=> !st.unstable)
    else $error("indicator not cleared");
  a_set_on_overload : assert property ( // [RULE2]
    ovl_trig |=> st.unstable ##1 (reg_rd && reg_addr ==
    gcf_pkg::OFS_INSTAB_CTL && !ovl_trig && !st.clr_pend) [*1] |=> reg_rdata[0])
    else $error("indicator not set");
  a_sticky_hold : assert property ( // [RULE3]
    st.unstable && !st.clr_pend |=> st.unstable)
    else $error("indicator lost");
  a_above_first : assert property ( // [RULE10]
    peak_valid && decimated_output > thr0 |=> st.above0)
    else $error("above first missed");
  a_above_second : assert property ( // [RULE11]
    peak_valid && decimated_output <= thr1 |=> !st.above1)
    else $error("above second wrong");
  a_pin_a_off : assert property ( // [RULE15]
    !st.en_a |=> !indicator_pin_a) else $error("pin a not low");
  a_pin_b_off : assert property ( // [RULE14]
    !st.en_b |=> !indicator_pin_b) else $error("pin b not low");
  a_combine_or : assert property ( // [RULE13]
    st.en_a && st.en_or && ovl_pulse |=> indicator_pin_a)
    else $error("combine missing");
  a_pulse_code : assert property ( // [RULE8]
    st.en_b && st.sel_b == gcf_pkg::SEL_OVL_PULSE && $rose(ovl_pulse)
    |=> indicator_pin_b) else $error("pulse not on pin b");
  a_unused_code : assert property ( // [RULE18]
    st.en_b && !st.en_or && st.sel_b inside {3'h1, 3'h2, 3'h3, 3'h7}
    |=> !indicator_pin_b) else $error("unused code drives pin");
  a_read_only_once : assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stale read data");

  c_pin_a_dwell : cover property (
    st.en_a && st.sel_a == gcf_pkg::SEL_DWELL ##1 indicator_pin_a);
  c_unstable_clear : cover property (st.unstable ##[1:20] !st.unstable);
  c_irq_raise : cover property ($rose(irq));

endmodule

/* hw/gcf_pkg.sv */
// Package of the gain-control flag logic: register map, field positions,
// reset values, select codes and widths.
// Assumes an 8-bit register port with a 9-bit word address.
package gcf_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam int unsigned ADDR_W = 9;
  localparam logic [8:0] OFS_OVL_LIMIT   = 9'h188;
  localparam logic [8:0] OFS_OVL_LEN     = 9'h189;
  localparam logic [8:0] OFS_INSTAB_CTL  = 9'h18F;
  localparam logic [8:0] OFS_UP0_LOW     = 9'h193;
  localparam logic [8:0] OFS_UP0_HIGH    = 9'h194;
  localparam logic [8:0] OFS_UP1_LOW     = 9'h195;
  localparam logic [8:0] OFS_UP1_HIGH    = 9'h196;
  localparam logic [8:0] OFS_LOWER_LOW   = 9'h197;
  localparam logic [8:0] OFS_LOWER_HIGH  = 9'h198;
  localparam logic [8:0] OFS_HOLD_FRAC   = 9'h199;
  localparam logic [8:0] OFS_HOLD_SCALE  = 9'h19A;
  localparam logic [8:0] OFS_PIN_A_SEL   = 9'h19B;
  localparam logic [8:0] OFS_PIN_B_SEL   = 9'h19C;
  localparam logic [8:0] OFS_PIN_ENABLE  = 9'h19E;
  localparam logic [8:0] OFS_IRQ_STATUS  = 9'h1A0;
  localparam logic [8:0] OFS_IRQ_MASK    = 9'h1A1;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_INSTAB     = 0;
  localparam int unsigned BIT_INSTAB_CLR = 1;
  localparam int unsigned BIT_EN_A       = 0;
  localparam int unsigned BIT_EN_B       = 1;
  localparam int unsigned BIT_EN_OR      = 4;
  localparam int unsigned EVT_OVERLOAD   = 0;
  localparam int unsigned EVT_ABOVE0     = 1;
  localparam int unsigned EVT_ABOVE1     = 2;
  localparam int unsigned EVT_DWELL      = 3;
  localparam int unsigned EVT_W          = 4;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam logic [2:0] RST_OVL_LIMIT = 3'h5;
  localparam logic [4:0] RST_OVL_LEN   = 5'h01;
  localparam int unsigned PEAK_W       = 12;
  localparam int unsigned SAMPLE_W     = 5;
  localparam int unsigned WINDOW_N     = 8;
  localparam int unsigned PULSE_UNIT   = 8;
  localparam int unsigned DWELL_W      = 24;
  localparam logic signed [4:0] FULL_SCALE = 5'sh08;

  // ****************************************************************
  // Flag select codes
  // ****************************************************************
  localparam logic [2:0] SEL_OVL_PULSE = 3'h0;
  localparam logic [2:0] SEL_ABOVE0    = 3'h4;
  localparam logic [2:0] SEL_ABOVE1    = 3'h5;
  localparam logic [2:0] SEL_DWELL     = 3'h6;

endpackage

/* hw/gcf_overload_det.sv */
// Converter overload detector: counts full-scale samples in a window of
// eight and issues the converter reset pulse.
// Assumes sample_valid marks one converter sample per strobe, same clock.
`timescale 1ns/1ps
module gcf_overload_det (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   soft_rst,
  input  wire logic                   sample_valid,
  input  wire logic signed [4:0]      sample,
  input  wire logic [2:0]             count_limit,
  input  wire logic [4:0]             pulse_length,
  output logic                        trigger,
  output logic                        pulse
);

  typedef struct packed {
    logic [7:0] hist;
    logic [8:0] remain;
    logic       trigger;
    logic       pulse;
  } gcf_det_t;

  gcf_det_t st;
  gcf_det_t next_st;

  // ****************************************************************
  // Window count and pulse timer
  // ****************************************************************
  always_comb begin
    logic [7:0] hist_n;
    logic [3:0] hits;
    logic       full;
    hist_n = st.hist;
    hits = 4'h0;
    next_st = st;
    next_st.trigger = 1'b0;
    full = (sample == gcf_pkg::FULL_SCALE) || (sample == -gcf_pkg::FULL_SCALE);
    if (sample_valid) begin
      hist_n = {st.hist[6:0], full};
    end
    for (int i = 0; i < gcf_pkg::WINDOW_N; i++) begin
      hits = hits + {3'h0, hist_n[i]};
    end
    next_st.hist = hist_n;
    if (sample_valid && (hits > {1'b0, count_limit})) begin // [RULE16]
      next_st.trigger = 1'b1;
      next_st.pulse = 1'b1;
      next_st.remain = 9'({4'h0, pulse_length} + 9'h001) << 3; // [RULE17]
    end else if (st.pulse && sample_valid) begin
      next_st.remain = st.remain - 9'h001;
      if (st.remain == 9'h001) begin
        next_st.pulse = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign trigger = st.trigger;
  assign pulse = st.pulse;

  a_pulse_on_trigger : assert property (@(posedge clk) disable iff (rst || soft_rst)
    st.trigger |-> st.pulse && st.remain != 9'h000) else $error("pulse not started"); // [RULE17]

endmodule

/* hw/gcf_dwell_timer.sv */
// Dwell timer: raises its flag once the decimated peak has stayed below
// the lower threshold for mantissa shifted left by exponent samples.
// Assumes peak_valid marks one decimated sample per strobe, same clock.
`timescale 1ns/1ps
module gcf_dwell_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  input  wire logic        peak_valid,
  input  wire logic [11:0] peak,
  input  wire logic [11:0] lower,
  input  wire logic [7:0]  mantissa,
  input  wire logic [3:0]  exponent,
  output logic             flag
);

  typedef struct packed {
    logic [23:0] count;
    logic        flag;
  } gcf_dwell_t;

  gcf_dwell_t st;
  gcf_dwell_t next_st;

  // ****************************************************************
  // Below-threshold run counter
  // ****************************************************************
  always_comb begin
    logic [23:0] limit;
    logic [23:0] count_n;
    limit = {16'h0000, mantissa} << exponent; // [RULE18]
    count_n = st.count;
    next_st = st;
    if (peak_valid) begin
      if (peak < lower) begin
        if (st.count != 24'hFFFFFF) begin
          count_n = st.count + 24'h000001;
        end
        next_st.flag = (count_n >= limit); // [RULE12]
      end else begin
        count_n = 24'h000000;
        next_st.flag = 1'b0;
      end
    end
    next_st.count = count_n;
  end

  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

  a_dwell_drop : assert property (@(posedge clk) disable iff (rst || soft_rst)
    peak_valid && !(peak < lower) |=> !flag) else $error("dwell flag held"); // [RULE12]

endmodule

/* dv/gcf_agc_model.sv */
// Model of the external gain-control logic that watches the flag pins.
// Assumes the pins are sampled on the device clock.
`timescale 1ns/1ps
module gcf_agc_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       pin_a,
  input  wire logic       pin_b,
  output logic [7:0]      a_high,
  output logic [7:0]      b_high
);
  // Counts the cycles each pin is seen high since the last clear.
  always_ff @(posedge clk) begin
    if (clr) begin
      a_high <= 8'h00;
      b_high <= 8'h00;
    end else begin
      a_high <= a_high + 8'(pin_a);
      b_high <= b_high + 8'(pin_b);
    end
  end
endmodule

/* dv/tb.sv */
// Self-checking testbench of the gain-control flag logic.
// Assumes the design package and the flag pin watcher model are compiled.
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              soft_rst = 1'b0;
  logic [8:0]        reg_addr = 9'h000;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              rd_d = 1'b0;
  logic              sample_valid = 1'b0;
  logic signed [4:0] sample = 5'sh00;
  logic              peak_valid = 1'b0;
  logic [11:0]       decimated_output = 12'h000;
  logic              mclr = 1'b1;
  logic [11:0]       thr;
  logic [7:0]        reg_rdata, a_high, b_high;
  logic              ovl, pin_a, pin_b, irq;
  logic [7:0]        exp_q[$];
  int                err_count = 0;
  int                compares = 0;
  int                seed = 7168;
  logic [8:0] ta[17] = '{9'h188, 9'h189, 9'h18F, 9'h193, 9'h194, 9'h195,
    9'h196, 9'h197, 9'h198, 9'h199, 9'h19A, 9'h19B, 9'h19C, 9'h19E,
    9'h1A0, 9'h1A1, 9'h1FF};
  logic [7:0] tm[17] = '{8'h07, 8'h1F, 8'h00, 8'hFF, 8'h0F, 8'hFF, 8'h0F,
    8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h07, 8'h07, 8'h13, 8'h00, 8'h0F, 8'h00};

  always #12.5 clk = ~clk;

  gcf_flag_logic dut (.clk(clk), .rst(rst), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample(sample), .peak_valid(peak_valid),
    .decimated_output(decimated_output), .overload_reset(ovl),
    .indicator_pin_a(pin_a), .indicator_pin_b(pin_b), .irq(irq));

  gcf_agc_model far (.clk(clk), .clr(mclr), .pin_a(pin_a), .pin_b(pin_b),
    .a_high(a_high), .b_high(b_high));

  // Counts the cycles the converter reset output is high since a clear.
  logic [7:0]        o_cnt = 8'h00;
  always @(posedge clk) begin
    if (mclr) begin
      o_cnt <= 8'h00;
    end else begin
      o_cnt <= o_cnt + 8'(ovl);
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    idle(2);
  endtask

  task automatic peak(input logic [11:0] v);
    decimated_output <= v;
    peak_valid <= 1'b1;
    @(posedge clk);
    peak_valid <= 1'b0;
    idle(3);
  endtask

  task automatic burst(input int n);
    mclr <= 1'b1;
    sample_valid <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      sample <= (i < n) ? (i[0] ? -gcf_pkg::FULL_SCALE : gcf_pkg::FULL_SCALE)
                        : 5'sh00;
      @(posedge clk);
      mclr <= 1'b0;
    end
    sample_valid <= 1'b0;
    idle(3);
  endtask

  // Read data stand in the cycle after the read strobe only.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    idle(20000);
    err_count++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    idle(10);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 17; i++) begin
      rd(ta[i], (i == 0) ? 8'h05 : (i == 1) ? 8'h01 : 8'h00);
      wr(ta[i], 8'hFF);
      rd(ta[i], tm[i]);
    end
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    $display("test registers done");
    wr(gcf_pkg::OFS_PIN_ENABLE, 8'h03);
    for (int k = 0; k < 2; k++) begin
      thr = 12'($random(seed)) & 12'hFFE;
      wr(k ? gcf_pkg::OFS_UP1_LOW : gcf_pkg::OFS_UP0_LOW, thr[7:0]);
      wr(k ? gcf_pkg::OFS_UP1_HIGH : gcf_pkg::OFS_UP0_HIGH, {4'h0, thr[11:8]});
      wr(k ? gcf_pkg::OFS_PIN_B_SEL : gcf_pkg::OFS_PIN_A_SEL, k ? 8'h05 : 8'h04);
      peak(thr);
      chk(k ? pin_b : pin_a, 8'h00);
      peak(thr + 12'h001);
      chk(k ? pin_b : pin_a, 8'h01);
    end
    for (int c = 1; c < 8; c++) begin
      if (c != 4 && c != 5 && c != 6) begin
        wr(gcf_pkg::OFS_PIN_B_SEL, 8'(c));
        idle(2);
        chk(pin_b, 8'h00);
      end
    end
    wr(gcf_pkg::OFS_PIN_B_SEL, 8'h05);
    peak(12'hFFF);
    chk({pin_b, pin_a}, 8'h03);
    wr(gcf_pkg::OFS_PIN_ENABLE, 8'h02);
    idle(2);
    chk({pin_b, pin_a}, 8'h02);
    wr(gcf_pkg::OFS_PIN_ENABLE, 8'h01);
    idle(2);
    chk({pin_b, pin_a}, 8'h01);
    $display("test peak compare done");
    wr(gcf_pkg::OFS_LOWER_LOW, 8'h10);
    wr(gcf_pkg::OFS_HOLD_FRAC, 8'h03);
    wr(gcf_pkg::OFS_HOLD_SCALE, 8'h01);
    wr(gcf_pkg::OFS_PIN_A_SEL, 8'h06);
    for (int i = 0; i < 6; i++) begin
      peak(12'h00F);
      chk(pin_a, 8'(i == 5));
    end
    peak(12'h010);
    chk(pin_a, 8'h00);
    $display("test dwell done");
    wr(gcf_pkg::OFS_OVL_LIMIT, 8'h07);
    wr(gcf_pkg::OFS_PIN_A_SEL, 8'h00);
    wr(gcf_pkg::OFS_IRQ_STATUS, 8'h0F);
    burst(7);
    rd(gcf_pkg::OFS_INSTAB_CTL, 8'h00);
    for (int l = 0; l < 4; l += 2) begin
      wr(gcf_pkg::OFS_OVL_LEN, 8'(l));
      wr(gcf_pkg::OFS_IRQ_MASK, 8'(l == 2));
      burst(8);
      chk(a_high, 8'((l + 1) * 8));
      chk(o_cnt, 8'((l + 1) * 8));
      chk(b_high, 8'h00);
      chk(irq, 8'(l == 2));
    end
    rd(gcf_pkg::OFS_INSTAB_CTL, 8'h01);
    wr(gcf_pkg::OFS_INSTAB_CTL, 8'h00);
    wr(gcf_pkg::OFS_IRQ_STATUS, 8'h01);
    rd(gcf_pkg::OFS_INSTAB_CTL, 8'h01);
    chk(irq, 8'h00);
    wr(gcf_pkg::OFS_INSTAB_CTL, 8'h02);
    rd(gcf_pkg::OFS_INSTAB_CTL, 8'h00);
    $display("test overload done");
    peak(12'h000);
    wr(gcf_pkg::OFS_PIN_A_SEL, 8'h04);
    wr(gcf_pkg::OFS_PIN_ENABLE, 8'h11);
    wr(gcf_pkg::OFS_OVL_LEN, 8'h00);
    burst(8);
    chk(a_high, 8'h08);
    chk(o_cnt, 8'h08);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    @(posedge clk);
    rd(gcf_pkg::OFS_INSTAB_CTL, 8'h00);
    rd(gcf_pkg::OFS_OVL_LIMIT, 8'h05);
    $display("test combine and soft reset done");
    results();
  end
endmodule
